// ---- rtl/ahnd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none

// Operation
// RULE_01 - With no parity, every selected source character must have its top bit clear.
// RULE_02 - With even parity, a character is valid only with an even count of ones.
// RULE_03 - With odd parity, a character is valid only with an odd count of ones.
// RULE_04 - Only the lower seven bits of a character give its converted value.
// RULE_05 - A parity mismatch raises the error flag and leaves the destination unchanged.
// RULE_06 - Error when the first source word and the next two lie in different areas.
// RULE_07 - Error when a selected character does not encode a hex digit 0 to F.
// RULE_08 - Error when an indirect data-memory pointer is not BCD or out of range.
// RULE_09 - With the execution condition false, the decoder does nothing.
// RULE_10 - Each selected source nibble is a bit index 0 to 15 set in its result.
// RULE_11 - Successive digits go to consecutive result words from the first one.
// RULE_12 - Only the two lowest selector digits are used, each from 0 to 3.
// RULE_13 - Lowest selector digit is the first digit, next digit is count minus one.
// RULE_14 - Digit selection past the top nibble wraps to nibble 0 of the source.
// RULE_15 - Error on an undefined selector or the last result word outside its area.
// RULE_16 - Source areas: all seven; result areas: internal, auxiliary, memory, holding, link.
// RULE_17 - Each written result word holds exactly one set bit at the decoded index.
module ahnd_decoder
  import ahnd_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Instruction step
  input wire logic req_valid,
  input wire ahnd_req_t req,
  // Results
  output logic done,
  output logic instruction_error_flag,
  output ahnd_rsp_t rsp
);

  // ----------------------------------------------------------------
  // Operand address checks
  // ----------------------------------------------------------------
  function automatic logic ahnd_fits(ahnd_operand_t o, logic [1:0] span);
    logic bcd_ok;
    logic [15:0] eff;
    bcd_ok = (o.addr[15:12] <= AHND_BCD_MAX) && (o.addr[11:8] <= AHND_BCD_MAX)
          && (o.addr[7:4] <= AHND_BCD_MAX) && (o.addr[3:0] <= AHND_BCD_MAX);
    eff = 16'({12'h000, o.addr[15:12]} * 16'd1000 + {12'h000, o.addr[11:8]} * 16'd100
          + {12'h000, o.addr[7:4]} * 16'd10 + {12'h000, o.addr[3:0]});
    if (o.indirect) begin
      // Pointer must itself be BCD and land inside memory
      if (!bcd_ok || o.area != AHND_AREA_DM) begin  // [RULE_08]
        return 1'b0;
      end
    end else begin
      eff = o.addr;
    end
    return ({1'b0, eff} + {15'h0000, span}) < ahnd_area_words(o.area);  // [RULE_08]
  endfunction

  function automatic logic ahnd_dst_area_ok(ahnd_area_t a);
    return a == AHND_AREA_IR || a == AHND_AREA_AR || a == AHND_AREA_DM
        || a == AHND_AREA_HR || a == AHND_AREA_LR;
  endfunction

  // ----------------------------------------------------------------
  // Per-code and per-digit datapath
  // ----------------------------------------------------------------
  logic [7:0] code [4];
  logic [3:0] code_val [4];
  logic [3:0] code_sel;
  logic [3:0] code_par_bad;
  logic [3:0] code_hex_bad;
  logic [15:0] onehot [4];
  logic [3:0] dig_sel;

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_lane
      logic [2:0] code_idx;
      logic [1:0] dig_idx;
      logic [3:0] nib;
      assign code_idx = 3'({2'b00, req.first_code} + 3'(k));
      assign code[k] = 8'(req.src_words >> {code_idx, 3'b000});
      assign code_sel[k] = 2'(k) <= req.code_count;
      always_comb begin
        unique case (req.parity)
          AHND_PAR_NONE: code_par_bad[k] = code[k][7];  // [RULE_01]
          AHND_PAR_EVEN: code_par_bad[k] = ^code[k];  // [RULE_02]
          AHND_PAR_ODD: code_par_bad[k] = ~^code[k];  // [RULE_03]
          default: code_par_bad[k] = 1'b1;
        endcase
      end
      // Parity bit is dropped before the digit lookup
      assign code_hex_bad[k] = !((code[k][6:0] >= AHND_ASC_ZERO && code[k][6:0] <= AHND_ASC_NINE)
        || (code[k][6:0] >= AHND_ASC_UPPER_A && code[k][6:0] <= AHND_ASC_UPPER_F));  // [RULE_07]
      assign code_val[k] = (code[k][6:0] <= AHND_ASC_NINE) ? code[k][3:0]
                         : 4'(code[k][3:0] + AHND_LETTER_BIAS);  // [RULE_04]
      // Two-bit index wraps past the top nibble on its own
      assign dig_idx = 2'(req.digit_selector[1:0] + 2'(k));  // [RULE_13] [RULE_14]
      assign nib = 4'(req.src_words[15:0] >> {dig_idx, 2'b00});
      assign onehot[k] = AHND_ONEHOT_BASE << nib;  // [RULE_10] [RULE_17]
      assign dig_sel[k] = 2'(k) <= req.digit_selector[5:4];  // [RULE_11] [RULE_13]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Error decisions and results
  // ----------------------------------------------------------------
  logic hex_err;
  logic dec_err;
  logic dsg_bad;
  logic [15:0] hex_word;
  logic [63:0] dec_words;

  assign dsg_bad = req.digit_selector[3:0] > AHND_DSG_MAX
                || req.digit_selector[7:4] > AHND_DSG_MAX;  // [RULE_12] [RULE_15]

  assign hex_err = !ahnd_fits(req.src, 2'd2)  // [RULE_06]
                || req.src.area == AHND_AREA_NONE
                || !ahnd_fits(req.dst, 2'd0) || !ahnd_dst_area_ok(req.dst.area)
                || |(code_sel & code_par_bad)  // [RULE_05]
                || |(code_sel & code_hex_bad);  // [RULE_07]

  assign dec_err = dsg_bad
                || req.src.area == AHND_AREA_NONE || !ahnd_fits(req.src, 2'd0)  // [RULE_16]
                || !ahnd_dst_area_ok(req.dst.area)  // [RULE_16]
                || !ahnd_fits(req.dst, req.digit_selector[5:4]);  // [RULE_15]

  always_comb begin
    logic [1:0] pos;
    hex_word = req.dst_word;
    pos = 2'b00;
    for (int i = 0; i < 4; i++) begin
      pos = 2'(req.dst_digit + 2'(i));
      if (code_sel[i]) begin
        hex_word = (hex_word & ~(16'h000f << {pos, 2'b00}))
                 | ({12'h000, code_val[i]} << {pos, 2'b00});
      end
    end
  end

  assign dec_words = {onehot[3], onehot[2], onehot[1], onehot[0]};  // [RULE_11]

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  ahnd_rsp_t next_rsp;
  logic next_done;
  logic next_err;

  always_comb begin
    next_rsp = rsp;
    next_rsp.wr_en = 4'h0;
    next_done = 1'b0;
    next_err = instruction_error_flag;
    if (req_valid) begin
      next_done = 1'b1;
      // False condition leaves flag and words untouched
      if (req.exec) begin  // [RULE_09]
        if (req.op == AHND_OP_HEX) begin
          next_err = hex_err;  // [RULE_05]
          if (!hex_err) begin
            next_rsp.wr_en = 4'h1;
            next_rsp.words = {48'h0000_0000_0000, hex_word};
          end
        end else begin
          next_err = dec_err;  // [RULE_15]
          if (!dec_err) begin
            next_rsp.wr_en = dig_sel;  // [RULE_11]
            next_rsp.words = dec_words;  // [RULE_17]
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '{wr_en: 4'h0, words: AHND_WORDS_RESET};
      done <= 1'b0;
      instruction_error_flag <= AHND_ERR_RESET;
    end else if (clk_en) begin
      rsp <= next_rsp;
      done <= next_done;
      instruction_error_flag <= next_err;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic fire;
  logic [3:0] exp_nib;
  assign fire = clk_en && req_valid && req.exec;
  assign exp_nib = (req.src_words[6:0] <= AHND_ASC_NINE) ? req.src_words[3:0]
                 : 4'(req.src_words[3:0] + AHND_LETTER_BIAS);

  sequence hex_step_s;
    fire && req.op == AHND_OP_HEX;
  endsequence

  sequence dec_ok_s;
    fire && req.op == AHND_OP_DECODE && !dec_err;
  endsequence

  no_parity_top_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_01]
    hex_step_s ##0 (req.parity == AHND_PAR_NONE && code[0][7]) |=> instruction_error_flag)
    else $error("top bit set without parity not flagged");

  even_parity_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_02]
    hex_step_s ##0 (req.parity == AHND_PAR_EVEN && ^code[0]) |=> instruction_error_flag)
    else $error("odd weight code passed even parity");

  odd_parity_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_03]
    hex_step_s ##0 (req.parity == AHND_PAR_ODD && !(^code[0])) |=> instruction_error_flag)
    else $error("even weight code passed odd parity");

  low_seven_bits_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_04]
    hex_step_s ##0 (!hex_err && !req.first_code && req.dst_digit == 2'd0)
    |=> rsp.words[3:0] == $past(exp_nib))
    else $error("converted digit not from low seven bits");

  error_no_write_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_05]
    hex_step_s ##0 (|(code_sel & code_par_bad)) |=> instruction_error_flag && rsp.wr_en == 4'h0)
    else $error("parity mismatch still wrote destination");

  source_span_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_06]
    hex_step_s ##0 (!req.src.indirect && {1'b0, req.src.addr} + 17'd2 >= ahnd_area_words(req.src.area))
    |=> instruction_error_flag)
    else $error("source words across areas not flagged");

  indirect_bad_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_08]
    fire ##0 (req.src.indirect && req.src.addr[3:0] > AHND_BCD_MAX) |=> instruction_error_flag)
    else $error("non-BCD pointer not flagged");

  idle_no_write_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_09]
    (clk_en && req_valid && !req.exec) |=> rsp.wr_en == 4'h0
      && instruction_error_flag == $past(instruction_error_flag))
    else $error("write or flag change with condition false");

  onehot_word_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_17]
    dec_ok_s |=> $onehot(rsp.words[15:0])
      && rsp.words[15:0] == (AHND_ONEHOT_BASE << $past(req.src_words[{req.digit_selector[1:0], 2'b00} +: 4])))
    else $error("first result word not one-hot at index");

  write_count_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_11]
    dec_ok_s |=> rsp.wr_en == 4'(5'h0f >> (2'd3 - $past(req.digit_selector[5:4]))) && done)
    else $error("wrong number of result words written");

  wrap_digit_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_14]
    dec_ok_s ##0 (req.digit_selector[5:0] == 6'h13)
    |=> rsp.words[31:16] == (AHND_ONEHOT_BASE << $past(req.src_words[3:0])))
    else $error("digit selection did not wrap to nibble 0");

  bad_selector_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_12]
    (fire && req.op == AHND_OP_DECODE && req.digit_selector[7:4] > AHND_DSG_MAX)
    |=> instruction_error_flag && rsp.wr_en == 4'h0)
    else $error("undefined selector not flagged");

  hex_range_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_07]
    hex_step_s ##0 (!req.first_code && (req.src_words[6:0] > AHND_ASC_UPPER_F
      || (req.src_words[6:0] > AHND_ASC_NINE && req.src_words[6:0] < AHND_ASC_UPPER_A)))
    |=> instruction_error_flag)
    else $error("non-hex code not flagged");

  pointer_digit_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_08]
    fire ##0 (req.dst.indirect && req.dst.addr[3:0] > AHND_BCD_MAX) |=> instruction_error_flag)
    else $error("non-BCD result pointer not flagged");

  result_overrun_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_15]
    (fire && req.op == AHND_OP_DECODE && !req.dst.indirect
      && {1'b0, req.dst.addr} + 17'(req.digit_selector[5:4]) >= ahnd_area_words(req.dst.area))
    |=> instruction_error_flag && rsp.wr_en == 4'h0)
    else $error("result words past area end not flagged");

  low_selector_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_15]
    (fire && req.op == AHND_OP_DECODE && req.digit_selector[3:0] > AHND_DSG_MAX)
    |=> instruction_error_flag && rsp.wr_en == 4'h0)
    else $error("undefined first digit not flagged");

  result_area_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_16]
    (fire && req.op == AHND_OP_DECODE
      && (req.dst.area == AHND_AREA_SR || req.dst.area == AHND_AREA_TC))
    |=> instruction_error_flag && rsp.wr_en == 4'h0)
    else $error("result in a read-only area not flagged");

  second_word_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_11]
    dec_ok_s ##0 (req.digit_selector[5:4] != 2'd0)
    |=> rsp.words[31:16] == (AHND_ONEHOT_BASE
      << $past(req.src_words[{2'(req.digit_selector[1:0] + 2'd1), 2'b00} +: 4])))
    else $error("second digit not in second result word");

  third_word_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_14]
    dec_ok_s ##0 (req.digit_selector[5:4] >= 2'd2)
    |=> rsp.words[47:32] == (AHND_ONEHOT_BASE
      << $past(req.src_words[{2'(req.digit_selector[1:0] + 2'd2), 2'b00} +: 4])))
    else $error("third digit not in third result word");

  fourth_word_a: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE_14]
    dec_ok_s ##0 (req.digit_selector[5:4] == 2'd3)
    |=> rsp.words[63:48] == (AHND_ONEHOT_BASE
      << $past(req.src_words[{2'(req.digit_selector[1:0] + 2'd3), 2'b00} +: 4])))
    else $error("fourth digit not in fourth result word");

endmodule // ahnd_decoder
`default_nettype wire

// ---- rtl/ahnd_pkg.sv ----
`default_nettype none
package ahnd_pkg;

  // ----------------------------------------------------------------
  // Data area sizes in words
  // ----------------------------------------------------------------
  localparam logic [16:0] AHND_IR_WORDS = 17'h00100;
  localparam logic [16:0] AHND_SR_WORDS = 17'h00010;
  localparam logic [16:0] AHND_AR_WORDS = 17'h00020;
  localparam logic [16:0] AHND_DM_WORDS = 17'h00800;
  localparam logic [16:0] AHND_HR_WORDS = 17'h00064;
  localparam logic [16:0] AHND_TC_WORDS = 17'h00200;
  localparam logic [16:0] AHND_LR_WORDS = 17'h00040;

  // ----------------------------------------------------------------
  // Codes, limits and reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] AHND_ASC_ZERO = 7'h30;
  localparam logic [6:0] AHND_ASC_NINE = 7'h39;
  localparam logic [6:0] AHND_ASC_UPPER_A = 7'h41;
  localparam logic [6:0] AHND_ASC_UPPER_F = 7'h46;
  localparam logic [3:0] AHND_LETTER_BIAS = 4'h9;
  localparam logic [3:0] AHND_DSG_MAX = 4'h3;
  localparam logic [3:0] AHND_BCD_MAX = 4'h9;
  localparam logic [15:0] AHND_ONEHOT_BASE = 16'h0001;
  localparam logic [63:0] AHND_WORDS_RESET = 64'h0000_0000_0000_0000;
  localparam logic AHND_ERR_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AHND_AREA_IR = 3'b000,
    AHND_AREA_SR = 3'b001,
    AHND_AREA_AR = 3'b010,
    AHND_AREA_DM = 3'b011,
    AHND_AREA_HR = 3'b100,
    AHND_AREA_TC = 3'b101,
    AHND_AREA_LR = 3'b110,
    AHND_AREA_NONE = 3'b111
  } ahnd_area_t;

  typedef enum logic [1:0] {
    AHND_PAR_NONE = 2'b00,
    AHND_PAR_EVEN = 2'b01,
    AHND_PAR_ODD = 2'b10
  } ahnd_parity_t;

  typedef enum logic {
    AHND_OP_HEX = 1'b0,
    AHND_OP_DECODE = 1'b1
  } ahnd_op_t;

  typedef struct packed {
    ahnd_area_t area;
    logic indirect;
    logic [15:0] addr;
  } ahnd_operand_t;

  typedef struct packed {
    ahnd_op_t op;
    logic exec;
    ahnd_operand_t src;
    ahnd_operand_t dst;
    logic [47:0] src_words;
    logic [15:0] dst_word;
    logic [15:0] digit_selector;
    logic [1:0] parity;
    logic first_code;
    logic [1:0] code_count;
    logic [1:0] dst_digit;
  } ahnd_req_t;

  typedef struct packed {
    logic [3:0] wr_en;
    logic [63:0] words;
  } ahnd_rsp_t;

  function automatic logic [16:0] ahnd_area_words(ahnd_area_t a);
    logic [16:0] n;
    unique case (a)
      AHND_AREA_IR: n = AHND_IR_WORDS;
      AHND_AREA_SR: n = AHND_SR_WORDS;
      AHND_AREA_AR: n = AHND_AR_WORDS;
      AHND_AREA_DM: n = AHND_DM_WORDS;
      AHND_AREA_HR: n = AHND_HR_WORDS;
      AHND_AREA_TC: n = AHND_TC_WORDS;
      AHND_AREA_LR: n = AHND_LR_WORDS;
      AHND_AREA_NONE: n = 17'h00000;
    endcase
    return n;
  endfunction

endpackage
`default_nettype wire

// ---- verification/test_ascii_hex_and_digit_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_ascii_hex_and_digit_decoder
  import ahnd_pkg::*;
;
  logic clock;
  logic rst_n;
  logic clk_en;
  logic req_valid;
  ahnd_req_t req;
  logic done;
  logic instruction_error_flag;
  ahnd_rsp_t rsp;
  int mismatches;
  int checks;
  int cycles;
  int i;
  logic bad;
  ahnd_req_t r;

  ahnd_decoder i_dut (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .req_valid(req_valid),
    .req(req),
    .done(done),
    .instruction_error_flag(instruction_error_flag),
    .rsp(rsp)
  );

  always #10 clock = ~clock;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic close_out();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Some forty steps of a few cycles each; far below this
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic note(input string what);
    mismatches++;
    $display("ERROR %0t: %s", $time, what);
  endtask

  task automatic cmp_flag(input logic exp);
    checks++;
    if (instruction_error_flag !== exp) note("error flag wrong");
  endtask

  task automatic cmp_wr(input logic [3:0] exp);
    checks++;
    if (rsp.wr_en !== exp) note("write enables wrong");
  endtask

  // Mask hides words whose hold value after a partial write is left open
  task automatic cmp_words(input logic [63:0] exp, input logic [63:0] m);
    checks++;
    if ((rsp.words & m) !== (exp & m)) note("result words wrong");
  endtask

  task automatic res(input logic f, input logic [3:0] w, input logic [63:0] d,
      input logic [63:0] m);
    cmp_flag(f);
    cmp_wr(w);
    cmp_words(d, m);
  endtask

  function automatic ahnd_req_t dcd(input logic [15:0] s, input logic [15:0] sel,
      input ahnd_area_t sa, input ahnd_area_t da, input logic ind, input logic [15:0] a);
    ahnd_req_t q;
    q = '0;
    q.op = AHND_OP_DECODE;
    q.exec = 1'b1;
    q.src.area = sa;
    q.dst = '{da, ind, a};
    q.src_words = {32'h0000_0000, s};
    q.digit_selector = sel;
    return q;
  endfunction

  // Format is {first_code, code_count, dst_digit}
  function automatic ahnd_req_t hx(input logic [47:0] s, input ahnd_parity_t p,
      input logic [4:0] fmt, input logic [15:0] dw, input logic [15:0] sa);
    ahnd_req_t q;
    q = '0;
    q.op = AHND_OP_HEX;
    q.exec = 1'b1;
    q.src.addr = sa;
    q.dst.area = AHND_AREA_DM;
    q.src_words = s;
    q.dst_word = dw;
    q.parity = p;
    {q.first_code, q.code_count, q.dst_digit} = fmt;
    return q;
  endfunction

  task automatic step(input ahnd_req_t q);
    int n;
    @(negedge clock);
    req = q;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    if (done !== 1'b1) note("no completion");
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req = '0;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    res(1'b0, 4'h0, 64'h0, '1);
    step(dcd(16'h06f0, 16'h0021, AHND_AREA_IR, AHND_AREA_HR, 1'b0, 16'h000a));
    res(1'b0, 4'h7, 64'h0001_0040_8000, 64'hffff_ffff_ffff);
    step(dcd(16'h1234, 16'h9933, AHND_AREA_IR, AHND_AREA_HR, 1'b0, 16'h000a));
    res(1'b0, 4'hf, 64'h0004_0008_0010_0002, '1);
    r = dcd(16'h0000, 16'h0000, AHND_AREA_IR, AHND_AREA_HR, 1'b0, 16'h000a);
    r.exec = 1'b0;
    step(r);
    res(1'b0, 4'h0, 64'h0004_0008_0010_0002, '1);
    step(dcd(16'h0000, 16'h0004, AHND_AREA_IR, AHND_AREA_HR, 1'b0, 16'h000a));
    res(1'b1, 4'h0, 64'h0004_0008_0010_0002, '1);
    step(r);
    res(1'b1, 4'h0, 64'h0004_0008_0010_0002, '1);
    step(dcd(16'h0000, 16'h0040, AHND_AREA_IR, AHND_AREA_HR, 1'b0, 16'h000a));
    res(1'b1, 4'h0, 64'h0004_0008_0010_0002, '1);
    step(dcd(16'h00f1, 16'h0020, AHND_AREA_IR, AHND_AREA_HR, 1'b0, 16'h0062));
    res(1'b1, 4'h0, 64'h0004_0008_0010_0002, '1);
    step(dcd(16'h00f1, 16'h0010, AHND_AREA_IR, AHND_AREA_HR, 1'b0, 16'h0062));
    res(1'b0, 4'h3, 64'h8000_0002, 64'hffff_ffff);
    for (i = 0; i < 7; i++) begin
      step(dcd(16'h0003, 16'h0000, ahnd_area_t'(i), AHND_AREA_HR, 1'b0, 16'h0000));
      res(1'b0, 4'h1, 64'h0008, 64'hffff);
      bad = (i == 1 || i == 5);
      step(dcd(16'h0005, 16'h0000, AHND_AREA_IR, ahnd_area_t'(i), 1'b0, 16'h0000));
      res(bad, {3'h0, ~bad}, bad ? 64'h0008 : 64'h0020, 64'hffff);
    end
    step(dcd(16'h0002, 16'h0000, AHND_AREA_IR, AHND_AREA_DM, 1'b1, 16'h0012));
    res(1'b0, 4'h1, 64'h0004, 64'hffff);
    step(dcd(16'h0002, 16'h0000, AHND_AREA_IR, AHND_AREA_DM, 1'b1, 16'h001a));
    res(1'b1, 4'h0, 64'h0004, 64'hffff);
    step(dcd(16'h0002, 16'h0000, AHND_AREA_IR, AHND_AREA_DM, 1'b1, 16'h2048));
    res(1'b1, 4'h0, 64'h0004, 64'hffff);
    step(dcd(16'h7001, 16'h0013, AHND_AREA_IR, AHND_AREA_HR, 1'b0, 16'h000a));
    res(1'b0, 4'h3, 64'h0002_0080, 64'hffff_ffff);
    r = dcd(16'h0002, 16'h0000, AHND_AREA_DM, AHND_AREA_HR, 1'b0, 16'h0000);
    r.src.indirect = 1'b1;
    r.src.addr = 16'h000b;
    step(r);
    res(1'b1, 4'h0, 64'h0002_0080, 64'hffff_ffff);
    // Enable low: an offered step must leave every output alone
    @(negedge clock);
    clk_en = 1'b0;
    req = dcd(16'h000f, 16'h0000, AHND_AREA_IR, AHND_AREA_HR, 1'b0, 16'h0000);
    req_valid = 1'b1;
    repeat (2) @(negedge clock);
    res(1'b1, 4'h0, 64'h0002_0080, 64'hffff_ffff);
    clk_en = 1'b1;
    req_valid = 1'b0;
    step(hx(48'h00b1, AHND_PAR_EVEN, 5'h00, 16'habcd, 16'h0000));
    res(1'b0, 4'h1, 64'habc1, 64'hffff);
    step(hx(48'h0031, AHND_PAR_EVEN, 5'h00, 16'h1234, 16'h0000));
    res(1'b1, 4'h0, 64'habc1, 64'hffff);
    step(hx(48'h0031, AHND_PAR_ODD, 5'h00, 16'h1230, 16'h0000));
    res(1'b0, 4'h1, 64'h1231, 64'hffff);
    step(hx(48'h00b1, AHND_PAR_ODD, 5'h00, 16'h1230, 16'h0000));
    res(1'b1, 4'h0, 64'h1231, 64'hffff);
    step(hx(48'h0031, AHND_PAR_NONE, 5'h00, 16'hff00, 16'h0000));
    res(1'b0, 4'h1, 64'hff01, 64'hffff);
    step(hx(48'h00b1, AHND_PAR_NONE, 5'h00, 16'hff00, 16'h0000));
    res(1'b1, 4'h0, 64'hff01, 64'hffff);
    step(hx(48'h0047, AHND_PAR_NONE, 5'h00, 16'h0000, 16'h0000));
    res(1'b1, 4'h0, 64'hff01, 64'hffff);
    step(hx(48'h003a, AHND_PAR_NONE, 5'h00, 16'h0000, 16'h0000));
    res(1'b1, 4'h0, 64'hff01, 64'hffff);
    step(hx(48'h3039_4632_4130, AHND_PAR_NONE, 5'h1e, 16'h0000, 16'h0000));
    res(1'b0, 4'h1, 64'h2a9f, 64'hffff);
    step(hx(48'h0046, AHND_PAR_NONE, 5'h00, 16'h0000, 16'h00fe));
    res(1'b1, 4'h0, 64'h2a9f, 64'hffff);
    step(hx(48'h0046, AHND_PAR_NONE, 5'h00, 16'h0000, 16'h00fd));
    res(1'b0, 4'h1, 64'h000f, 64'hffff);
    close_out();
  end
endmodule // test_ascii_hex_and_digit_decoder
`default_nettype wire
